// [verilog/ffmd_top.sv]
// Freefall/motion detector with register file, debounce and interrupt
//
// Strobed register access was left to the implementer.
`default_nettype none
module ffmd_top #(
  parameter int SAMPLE_W = 14
) (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire ffmd_pkg::ffmd_bus_s   bus,
  output var  logic [7:0]            rdata,
  input  wire ffmd_pkg::ffmd_sample_s sample,
  output var  logic                  event_active_flag,
  output var  logic                  irq
);

  // Sample path: per-axis magnitude against threshold, then AND/OR combine, then debounce.
  // All of it is combinational but only committed on a sample strobe,
  // so register writes between samples cannot raise an event on their own.

  // Widths and counts local to this block
  localparam int         IRQ_W_L   = ffmd_pkg::IRQ_W;
  localparam int         AXES      = 3;
  localparam int         MAG_W     = SAMPLE_W - 1;
  localparam int         THR_W     = 13;
  localparam int         OWN_MSB_W = THR_W - 8;
  localparam int         AXIS_REGS = 2 * AXES;
  localparam logic [7:0] CNT_MAX   = 8'hff;
  localparam logic [7:0] CNT_ZERO  = 8'h00;
  localparam logic [7:0] CNT_ONE   = 8'h01;

  // Axis order in every per-axis vector
  localparam int         AXIS_X    = 0;
  localparam int         AXIS_Y    = 1;
  localparam int         AXIS_Z    = 2;

  typedef struct packed {
    logic [7:0]                cfg;
    logic [7:0]                ths;
    logic [7:0]                count;
    logic [AXIS_REGS-1:0][7:0] axis_ths;
    logic [7:0]                src;
    logic [7:0]                dbcnt;
    logic [IRQ_W_L-1:0]        irq_stat;
    logic [IRQ_W_L-1:0]        irq_mask;
    logic [7:0]                rdata;
    logic                      irq;
  } ffmd_state_s;

  localparam ffmd_state_s STATE_RESET = '{
    cfg:      ffmd_pkg::CFG_RESET,
    ths:      ffmd_pkg::THS_RESET,
    count:    ffmd_pkg::COUNT_RESET,
    axis_ths: '0,
    src:      ffmd_pkg::SRC_RESET,
    dbcnt:    CNT_ZERO,
    irq_stat: '0,
    irq_mask: '0,
    rdata:    8'h00,
    irq:      1'b0
  };

  ffmd_state_s s;
  ffmd_state_s next_s;

  // Configuration decode
  logic [AXES-1:0]     en;
  logic                motion;
  logic                latch_on;
  logic                per_axis;
  logic                clear_mode;
  logic [THR_W-1:0]    common_thr;

  // Per-axis detection
  logic [SAMPLE_W-1:0] axis_sample [AXES];
  logic [MAG_W-1:0]    axis_mag    [AXES];
  logic [THR_W-1:0]    axis_thr    [AXES];
  logic [AXES-1:0]     above;
  logic [AXES-1:0]     below;
  logic [AXES-1:0]     hit;
  logic [AXES-1:0]     neg;
  logic [AXES-1:0]     pol;

  // Combination, debounce and source word
  logic                any_en;
  logic                all_low;
  logic                any_high;
  logic                cond;
  logic [7:0]          dbcnt_step;
  logic                deb;
  logic [7:0]          fresh_src;
  logic                held;
  logic                src_update;
  logic                ea_rise;

  // Register bus decode
  logic                sel_cfg;
  logic                sel_src;
  logic                sel_ths;
  logic                sel_count;
  logic                sel_stat;
  logic                sel_mask;
  logic                in_axis_range;
  logic [2:0]          axis_idx;
  logic [7:0]          read_value;
  logic                src_read;
  logic                wr_cfg;
  logic                wr_ths;
  logic                wr_count;
  logic                wr_stat;
  logic                wr_mask;
  logic                wr_axis;

  assign en[AXIS_X]   = s.cfg[ffmd_pkg::CFG_XEN];
  assign en[AXIS_Y]   = s.cfg[ffmd_pkg::CFG_YEN];
  assign en[AXIS_Z]   = s.cfg[ffmd_pkg::CFG_ZEN];
  assign motion       = s.cfg[ffmd_pkg::CFG_OR];
  assign latch_on     = s.cfg[ffmd_pkg::CFG_LATCH];
  assign per_axis     = s.axis_ths[0][ffmd_pkg::THS_XYZ_EN];
  assign clear_mode   = s.ths[ffmd_pkg::THS_DBMODE];
  // Common threshold lands on the upper bits of the magnitude scale
  assign common_thr   = {s.ths[6:0], {ffmd_pkg::THS_SHIFT{1'b0}}};

  assign axis_sample[AXIS_X] = sample.x;
  assign axis_sample[AXIS_Y] = sample.y;
  assign axis_sample[AXIS_Z] = sample.z;

  for (genvar a = 0; a < AXES; a++) begin : g_axis
    logic [SAMPLE_W-1:0] absv;
    logic                is_min;
    logic [7:0]          own_hi;
    logic [7:0]          own_lo;
    logic [THR_W-1:0]    own_thr;
    assign neg[a]      = axis_sample[a][SAMPLE_W-1];
    // Two's complement negate of a negative sample
    assign absv        = neg[a] ? (~axis_sample[a] + SAMPLE_W'(1)) : axis_sample[a];
    // Most negative code would wrap to zero, so it saturates instead
    assign is_min      = absv[SAMPLE_W-1];
    assign axis_mag[a] = is_min ? {MAG_W{1'b1}} : absv[MAG_W-1:0];
    // High register is the even one of each pair; its upper bits are ignored
    assign own_hi      = s.axis_ths[2*a];
    assign own_lo      = s.axis_ths[2*a+1];
    assign own_thr     = {own_hi[OWN_MSB_W-1:0], own_lo};
    assign axis_thr[a] = per_axis ? own_thr : common_thr;
    assign above[a]    = axis_mag[a] > axis_thr[a];
    assign below[a]    = axis_mag[a] < axis_thr[a];
    assign hit[a]      = en[a] && (motion ? above[a] : below[a]);
    assign pol[a]      = hit[a] & neg[a];
  end

  // Nothing enabled gives no event in either mode
  assign any_en   = |en;
  assign all_low  = any_en && ((hit | ~en) == {AXES{1'b1}});
  assign any_high = |hit;
  // Motion takes any enabled high axis, freefall needs every enabled axis low
  assign cond     = motion ? any_high : all_low;

  // Counter step, committed only when a fresh sample lands
  always_comb begin
    dbcnt_step = s.dbcnt;
    if (cond) begin
      if (s.dbcnt != CNT_MAX) begin
        dbcnt_step = s.dbcnt + CNT_ONE;
      end
    end else if (clear_mode) begin
      dbcnt_step = CNT_ZERO;
    end else if (s.dbcnt != CNT_ZERO) begin
      dbcnt_step = s.dbcnt - CNT_ONE;
    end
  end

  // A zero count passes the condition straight through; otherwise the stepped counter must exceed count
  assign deb = cond && ((dbcnt_step > s.count) || (s.count == CNT_ZERO));

  assign fresh_src = {
    deb,
    1'b0,
    hit[AXIS_Z],
    pol[AXIS_Z],
    hit[AXIS_Y],
    pol[AXIS_Y],
    hit[AXIS_X],
    pol[AXIS_X]
  };

  // A held event freezes the whole source word until it is read
  assign held       = latch_on && s.src[ffmd_pkg::SRC_EA];
  assign src_update = sample.valid && !held;
  assign ea_rise    = src_update && deb && !s.src[ffmd_pkg::SRC_EA];

  // Address decode shared by reads and writes
  assign sel_cfg   = bus.addr == ffmd_pkg::ADDR_CFG;
  assign sel_src   = bus.addr == ffmd_pkg::ADDR_SRC;
  assign sel_ths   = bus.addr == ffmd_pkg::ADDR_THS;
  assign sel_count = bus.addr == ffmd_pkg::ADDR_COUNT;
  assign sel_stat  = bus.addr == ffmd_pkg::ADDR_IRQ_STAT;
  assign sel_mask  = bus.addr == ffmd_pkg::ADDR_IRQ_MASK;
  // Per-axis threshold pairs: high register at even index, low at odd
  assign in_axis_range = (bus.addr >= ffmd_pkg::ADDR_THS_XM) && (bus.addr <= ffmd_pkg::ADDR_THS_ZL);
  assign axis_idx      = 3'(bus.addr - ffmd_pkg::ADDR_THS_XM);

  // Only a read of the source register may clear a held event
  assign src_read = bus.rd && sel_src;

  assign wr_cfg   = bus.wr && sel_cfg;
  assign wr_ths   = bus.wr && sel_ths;
  assign wr_count = bus.wr && sel_count;
  assign wr_stat  = bus.wr && sel_stat;
  assign wr_mask  = bus.wr && sel_mask;
  assign wr_axis  = bus.wr && in_axis_range;

  // Read mux; unmapped addresses read as zero
  always_comb begin
    read_value = 8'h00;
    unique case (bus.addr)
      ffmd_pkg::ADDR_CFG: begin
        read_value = {s.cfg[7:3], 3'h0};
      end
      ffmd_pkg::ADDR_SRC: begin
        read_value = s.src;
      end
      ffmd_pkg::ADDR_THS: begin
        read_value = s.ths;
      end
      ffmd_pkg::ADDR_COUNT: begin
        read_value = s.count;
      end
      ffmd_pkg::ADDR_IRQ_STAT: begin
        read_value = 8'(s.irq_stat);
      end
      ffmd_pkg::ADDR_IRQ_MASK: begin
        read_value = 8'(s.irq_mask);
      end
      default: begin
        if (in_axis_range) begin
          read_value = s.axis_ths[axis_idx];
        end
      end
    endcase
  end

  always_comb begin
    next_s = s;

    // Debounce runs only when a fresh sample lands
    if (sample.valid) begin
      next_s.dbcnt = dbcnt_step;
    end

    if (src_update) begin
      next_s.src = fresh_src;
    end else if (src_read && latch_on) begin
      // A read clears a held event; a sample in the same cycle is dropped, since the hold blocks it
      next_s.src = ffmd_pkg::SRC_RESET;
    end

    // Read data stand for exactly one cycle after the strobe
    next_s.rdata = 8'h00;
    if (bus.rd) begin
      next_s.rdata = read_value;
    end

    // Reserved low bits never store
    if (wr_cfg) begin
      next_s.cfg = {bus.wdata[7:3], 3'h0};
    end
    if (wr_ths) begin
      next_s.ths = bus.wdata;
    end
    if (wr_count) begin
      next_s.count = bus.wdata;
    end
    if (wr_mask) begin
      next_s.irq_mask = bus.wdata[IRQ_W_L-1:0];
    end
    // Writing a one clears a status bit
    if (wr_stat) begin
      next_s.irq_stat = s.irq_stat & ~bus.wdata[IRQ_W_L-1:0];
    end
    // Source register and unmapped writes are dropped
    if (wr_axis) begin
      next_s.axis_ths[axis_idx] = bus.wdata;
    end

    // Rising event flag sets the sticky bit; set beats a same-cycle clear
    if (ea_rise) begin
      next_s.irq_stat[ffmd_pkg::IRQ_EVENT] = 1'b1;
    end
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  // Asynchronous reset loads constants only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register
  assign rdata             = s.rdata;
  assign event_active_flag = s.src[ffmd_pkg::SRC_EA];
  assign irq               = s.irq;
endmodule : ffmd_top
`default_nettype wire

// [verilog/ffmd_pkg.sv]
// Package with register map, field layout and carrier types of the freefall/motion detector
//
// Overview of operation
// - With the combine bit clear, the event flag rises only when every enabled axis shows low g.
// - With the combine bit set, the event flag rises when any enabled axis shows high g.
// - The common threshold lives at 0x17 and the per-axis thresholds at 0x73 through 0x78.
// - With latching on, the event flag holds once set and clears only on a read of the source register.
// - With latching off, the event flag follows the current detection result every sample.
// - The logic that sets the event flag passes through a debounce stage whose mode a control bit selects.
// - Each axis has its own enable, and a disabled axis gives no event and drops out of the combination.
// - With the per-axis select bit at 0, all axes compare against one shared unsigned 7-bit threshold.
// - With the per-axis select bit at 1, each axis compares against its own unsigned 13-bit threshold.
// - With latching on, the per-axis flags in the source register freeze when the event flag sets.
// - While a latched event is held, new axis events do not change the source register until it is read.
// - An enabled axis raises its flag above the threshold in motion mode or below it in freefall mode.
// - The configuration register resets to zero, and its three low bits are reserved.
// - With debounce mode 1, the debounce counter clears to zero as soon as the condition drops.
// - With debounce mode 0, the counter steps down by one per sample while the condition is false.
package ffmd_pkg;
  localparam logic [7:0] ADDR_CFG      = 8'h15;
  localparam logic [7:0] ADDR_SRC      = 8'h16;
  localparam logic [7:0] ADDR_THS      = 8'h17;
  localparam logic [7:0] ADDR_COUNT    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h19;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1a;
  localparam logic [7:0] ADDR_THS_XM   = 8'h73;
  localparam logic [7:0] ADDR_THS_ZL   = 8'h78;
  // Configuration fields
  localparam int CFG_LATCH = 7;
  localparam int CFG_OR    = 6;
  localparam int CFG_ZEN   = 5;
  localparam int CFG_YEN   = 4;
  localparam int CFG_XEN   = 3;
  // Threshold fields
  localparam int THS_DBMODE  = 7;
  localparam int THS_XYZ_EN  = 7;
  // Source fields
  localparam int SRC_EA = 7;
  // Interrupt status bits
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_W     = 1;
  // Common threshold sits at bit 6 of the 13-bit magnitude scale
  localparam int THS_SHIFT = 6;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] THS_RESET   = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] SRC_RESET   = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ffmd_bus_s;

  typedef struct packed {
    logic        valid;
    logic [13:0] x;
    logic [13:0] y;
    logic [13:0] z;
  } ffmd_sample_s;
endpackage : ffmd_pkg

// [tb/ffmd_top_chk.sv]
// Port-level assertions of the freefall/motion detector
`default_nettype none
module ffmd_top_chk (
  input wire logic                   clock,
  input wire logic                   rstn,
  input wire ffmd_pkg::ffmd_bus_s    bus,
  input wire logic [7:0]             rdata,
  input wire ffmd_pkg::ffmd_sample_s sample,
  input wire logic                   event_active_flag,
  input wire logic                   irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire rd_src = bus.rd && bus.addr == 8'h16;
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property ($past(bus.rd && bus.addr == 8'h00) |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_cfg_reserved: assert property ($past(bus.rd && bus.addr == 8'h15) |-> rdata[2:0] == 3'h0)
    else $error("reserved configuration bits not zero");
  a_src_gap: assert property ($past(rd_src) |-> !rdata[6])
    else $error("unused source bit set");
  a_flag_rise: assert property ($rose(event_active_flag) |-> $past(sample.valid))
    else $error("event flag rose without a sample");
  a_flag_fall: assert property ($fell(event_active_flag) |-> $past(sample.valid || rd_src || bus.wr))
    else $error("event flag fell without cause");
  a_irq_rise: assert property ($rose(irq) |-> $past(sample.valid) || $past(bus.wr) || $past(bus.wr, 2))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(bus.wr) || $past(bus.wr, 2))
    else $error("interrupt fell without a write");
endmodule : ffmd_top_chk
bind ffmd_top ffmd_top_chk chk (.clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .sample(sample),
  .event_active_flag(event_active_flag), .irq(irq));
`default_nettype wire

// [tb/ffmd_top_bench.sv]
// Register-level bench of the freefall/motion detector
`default_nettype none
module ffmd_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clock = 1'b0;
  logic                   rstn = 1'b0;
  ffmd_pkg::ffmd_bus_s    bus = '0;
  ffmd_pkg::ffmd_sample_s sample = '0;
  logic [7:0]             rdata;
  logic                   event_active_flag;
  logic                   irq;
  int                     fails = 0;
  int                     num_checks = 0;
  localparam logic [13:0] HI = 14'h0064, NEG = 14'h3f9c, LO = 14'h000a;
  ffmd_top uut (.clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .sample(sample),
    .event_active_flag(event_active_flag), .irq(irq));
  initial forever #5 clock = ~clock;
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clock) bus <= '0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) bus <= '0;
    #1 cmp(rdata, e);
  endtask : rd
  task smp(input logic [13:0] x, input logic [13:0] y, input logic e);
    @(posedge clock) sample <= '{1'b1, x, y, 14'h0000};
    @(posedge clock) sample.valid <= 1'b0;
    #1 cmp({7'h00, event_active_flag}, {7'h00, e});
  endtask : smp
  // Y and Z stay low so X alone decides
  task seq(input logic [7:0] pat, input int n);
    for (int i = 0; i < n; i++) smp(pat[i] ? HI : LO, LO, 1'b0);
  endtask : seq
  task ci(input logic e);
    @(posedge clock) #1 cmp({7'h00, irq}, {7'h00, e});
  endtask : ci
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #300000;
    fails++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd(8'h15, 8'h00);
    wr(8'h15, 8'hff);
    rd(8'h15, 8'hf8);
    rd(8'h00, 8'h00);
    wr(8'h17, 8'h01);
    rd(8'h17, 8'h01);
    $display("test 1 done");
    wr(8'h15, 8'h48);
    smp(HI, LO, 1'b1);
    rd(8'h16, 8'h82);
    smp(NEG, LO, 1'b1);
    rd(8'h16, 8'h83);
    smp(LO, LO, 1'b0);
    smp(LO, HI, 1'b0);
    wr(8'h15, 8'h18);
    smp(LO, HI, 1'b0);
    smp(LO, LO, 1'b1);
    smp(HI, HI, 1'b0);
    $display("test 2 done");
    wr(8'h15, 8'hc8);
    smp(HI, LO, 1'b1);
    smp(LO, LO, 1'b1);
    smp(NEG, LO, 1'b1);
    rd(8'h16, 8'h82);
    repeat (2) @(posedge clock);
    cmp({7'h00, event_active_flag}, 8'h00);
    $display("test 3 done");
    wr(8'h15, 8'h48);
    wr(8'h73, 8'h80);
    wr(8'h74, 8'h20);
    smp(14'h0028, LO, 1'b1);
    smp(14'h001e, LO, 1'b0);
    wr(8'h73, 8'h00);
    smp(14'h0028, LO, 1'b0);
    $display("test 4 done");
    wr(8'h18, 8'h02);
    rd(8'h18, 8'h02);
    wr(8'h17, 8'h81);
    seq(8'h36, 6);
    smp(HI, LO, 1'b1);
    wr(8'h17, 8'h01);
    seq(8'hb0, 8);
    smp(HI, LO, 1'b1);
    $display("test 5 done");
    wr(8'h18, 8'h00);
    wr(8'h1a, 8'h01);
    ci(1'b1);
    wr(8'h19, 8'h01);
    ci(1'b0);
    wr(8'h1a, 8'h00);
    smp(LO, LO, 1'b0);
    smp(HI, LO, 1'b1);
    ci(1'b0);
    rd(8'h19, 8'h01);
    wr(8'h1a, 8'h01);
    ci(1'b1);
    rd(8'h1a, 8'h01);
    $display("test 6 done");
    summarize();
  end
endmodule : ffmd_top_bench
`default_nettype wire
